/* File: design/supervisor_pkg.sv */
// Operation
// - mode from two stored flags: 00 slave, 10 master, 11 repeater, 01 monitor
// - flags loaded at every initialization; mode never changes while running
// - storage writes and port operations only in slave mode
// - start at 16 MHz setting, after about 200 us follow crystal detection
// - crystal detection stays active until first error-free telegram, then freezes
// - slave locks on master call; other modes lock on call or response
// - clock watchdog resets device when oscillation missing over 20 us
// - over 140 C for over 2 s: inductor off, reset, analog power-down
// - over-temperature shutdown held until bus supply power cycle
// - inductor output short to ground gives same latched shutdown
// - first pulse amplitude from 3-bit converter sets thresholds at half
// - slave mode checks syntax and timing, strobes only correct telegrams
// - main state machine receives decoded word, returns response data
// - response data sent as Manchester-II stream to transmitter
// - master mode strobes each correct slave response
// - monitor mode gives separate master and slave telegram strobes
// - aux pin: addressing input in slave, direct transmit input in master
// - fail pin: CMOS input in slave, power-fail comparator in master
// - aux channel auto-detects photodiode current or CMOS signal
// - with aux channel active, response goes inverted on first indicator
// - aux channel enabled by activation sequence, disabled on any reset
package supervisor_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned CLK_PERIOD_PS = 1000000000 / (CLK_HZ / 1000);
  localparam int unsigned DETECT_TIME_US = 200;
  localparam int unsigned DETECT_CYCLES = DETECT_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned WATCHDOG_TIME_US = 20;
  localparam int unsigned WATCHDOG_CYCLES = WATCHDOG_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned OVERTEMP_TIME_MS = 2000;
  localparam int unsigned OVERTEMP_CYCLES = OVERTEMP_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned BIT_TIME_NS = 6000;
  localparam int unsigned HALF_BIT_CYCLES = (BIT_TIME_NS * 1000 / 2) / CLK_PERIOD_PS;
  localparam int unsigned BIT_CYCLES = 2 * HALF_BIT_CYCLES;
  localparam int unsigned SAMPLE_FIRST = HALF_BIT_CYCLES / 2;
  localparam int unsigned SAMPLE_SECOND = HALF_BIT_CYCLES + HALF_BIT_CYCLES / 2;

  // ---------------------------------------------------------------
  // counter widths
  // ---------------------------------------------------------------
  localparam int unsigned BIT_CNT_W = 8;
  localparam int unsigned DETECT_CNT_W = 14;
  localparam int unsigned WATCHDOG_CNT_W = 10;
  localparam int unsigned OVERTEMP_CNT_W = 27;

  // ---------------------------------------------------------------
  // telegram layout and reset values
  // ---------------------------------------------------------------
  localparam int unsigned MASTER_CALL_BITS = 14;
  localparam int unsigned SLAVE_RESP_BITS = 7;
  localparam int unsigned RESP_DATA_BITS = 4;
  localparam int unsigned TX_HALVES = 2 * SLAVE_RESP_BITS;
  localparam int unsigned AMP_BITS = 3;
  localparam logic FREQ_16_RESET = 1'b1;
  localparam logic [13:0] ACTIVATION_CALL_DEFAULT = 14'h0001;

  typedef enum logic [1:0] {
    MODE_SLAVE,
    MODE_MASTER,
    MODE_REPEATER,
    MODE_MONITOR
  } mode_e;

endpackage

/* File: design/telegram_checker.sv */
`timescale 1ns/100ps
module telegram_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic line_raw,
  input wire logic enable,
  output logic master_call_ok,
  output logic slave_resp_ok,
  output logic [13:0] word
);

  typedef enum logic {RX_IDLE, RX_BITS} rx_state_e;

  logic s1, s2, s3, line;
  rx_state_e state;
  logic [supervisor_pkg::BIT_CNT_W-1:0] cyc;
  logic [3:0] nbits;
  logic [13:0] shift;
  logic h1;
  logic done;

  // ---------------------------------------------------------------
  // line synchroniser
  // ---------------------------------------------------------------
  // line idles high, so reset values keep a false start away
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      line <= 1'b1;
    end else begin
      s1 <= line_raw;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        line <= s3;
      end
    end
  end

  // ---------------------------------------------------------------
  // manchester demodulation
  // ---------------------------------------------------------------
  // bit value is the first half; both halves high marks the end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= RX_IDLE;
      cyc <= '0;
      nbits <= '0;
      shift <= '0;
      h1 <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        RX_IDLE: begin
          if (enable && !line) begin
            state <= RX_BITS;
            cyc <= 8'd1;
            nbits <= '0;
            shift <= '0;
          end
        end
        RX_BITS: begin
          if (cyc == 8'(supervisor_pkg::BIT_CYCLES - 1)) begin
            cyc <= '0;
          end else begin
            cyc <= cyc + 8'd1;
          end
          if (cyc == 8'(supervisor_pkg::SAMPLE_FIRST)) begin
            h1 <= line;
          end
          if (!enable) begin
            state <= RX_IDLE;
          end else if (cyc == 8'(supervisor_pkg::SAMPLE_SECOND)) begin
            if (h1 != line) begin
              shift <= {shift[12:0], h1};
              nbits <= nbits + 4'd1;
              // too long for any telegram: drop it
              if (nbits == 4'(supervisor_pkg::MASTER_CALL_BITS)) begin
                state <= RX_IDLE;
              end
            end else if (h1) begin
              done <= 1'b1;
              state <= RX_IDLE;
            end else begin
              state <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // frame checks and result pulses
  // ---------------------------------------------------------------
  // start bit 0, end bit 1, even parity over the middle bits
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      master_call_ok <= 1'b0;
      slave_resp_ok <= 1'b0;
      word <= '0;
    end else begin
      master_call_ok <= done && nbits == 4'(supervisor_pkg::MASTER_CALL_BITS)
        && !shift[13] && shift[0] && !(^shift[12:1]);
      slave_resp_ok <= done && nbits == 4'(supervisor_pkg::SLAVE_RESP_BITS)
        && !shift[6] && shift[0] && !(^shift[5:1]);
      if (done) begin
        word <= shift;
      end
    end
  end

endmodule

/* File: design/node_mode_supervisor.sv */
`timescale 1ns/100ps
module node_mode_supervisor #(
  parameter int unsigned DETECT_CYCLES = supervisor_pkg::DETECT_CYCLES,
  parameter int unsigned OVERTEMP_CYCLES = supervisor_pkg::OVERTEMP_CYCLES,
  parameter logic [13:0] ACTIVATION_CALL = supervisor_pkg::ACTIVATION_CALL_DEFAULT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic nvm_ready,
  input wire logic nvm_master_flag,
  input wire logic nvm_repeater_flag,
  input wire logic bus_rx_line,
  input wire logic amp_valid,
  input wire logic [2:0] amp_code,
  input wire logic osc_activity,
  input wire logic crystal_is_8mhz,
  input wire logic temp_high,
  input wire logic inductor_short,
  input wire logic fail_input_pin,
  input wire logic fail_comparator,
  input wire logic aux_channel_pin,
  input wire logic aux_current_detect,
  input wire logic resp_load,
  input wire logic [3:0] resp_data,
  output logic mode_slave,
  output logic mode_master,
  output logic mode_repeater,
  output logic mode_monitor,
  output logic mode_valid,
  output logic nvm_write_enable,
  output logic io_enable,
  output logic freq_16mhz,
  output logic freq_locked,
  output logic device_reset,
  output logic inductor_enable,
  output logic analog_power_down,
  output logic [2:0] pos_threshold,
  output logic [2:0] neg_threshold,
  output logic strobe_master_call,
  output logic strobe_slave_resp,
  output logic [13:0] rx_word,
  output logic tx_enable,
  output logic tx_manchester,
  output logic first_indicator_pin,
  output logic aux_enabled,
  output logic aux_current_path,
  output logic fail_digital_level,
  output logic fail_comparator_enable,
  output logic power_fail
);

  localparam int unsigned NPINS = 8;

  supervisor_pkg::mode_e mode;
  logic [NPINS-1:0] pin_raw, s1, s2, s3, pin;
  logic osc_s, xtal8_s, temp_s, short_s, fail_s, fcmp_s, auxc_s;
  logic dev_rst;
  logic shutdown;
  logic osc_prev;
  logic wd_active;
  logic [supervisor_pkg::WATCHDOG_CNT_W-1:0] wd_cnt;
  logic [supervisor_pkg::OVERTEMP_CNT_W-1:0] temp_cnt;
  logic trip;
  logic [supervisor_pkg::DETECT_CNT_W-1:0] det_cnt;
  logic det_done;
  logic is_slave, is_master_family;
  logic bus_mc, bus_sr, aux_mc;
  logic [13:0] bus_word, aux_word;
  logic aux_magic;
  logic lock_event;
  logic rx_enable, aux_rx_enable;
  logic tx_busy;
  logic [6:0] tx_shift;
  logic [3:0] tx_half;
  logic [supervisor_pkg::BIT_CNT_W-1:0] tx_cnt;
  logic tx_level;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  assign pin_raw = {aux_channel_pin, aux_current_detect, fail_comparator, fail_input_pin,
                    inductor_short, temp_high, crystal_is_8mhz, osc_activity};
  assign osc_s = pin[0];
  assign xtal8_s = pin[1];
  assign temp_s = pin[2];
  assign short_s = pin[3];
  assign fail_s = pin[4];
  assign fcmp_s = pin[5];
  assign auxc_s = pin[6];

  // three stages; a change counts once stages two and three agree
  for (genvar i = 0; i < NPINS; i++) begin : g_sync
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        s1[i] <= 1'b0;
        s2[i] <= 1'b0;
        s3[i] <= 1'b0;
        pin[i] <= 1'b0;
      end else begin
        s1[i] <= pin_raw[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i]) begin
          pin[i] <= s3[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // telegram checkers, bus and aux channel
  // ---------------------------------------------------------------
  assign rx_enable = mode_valid && !shutdown;
  assign aux_rx_enable = rx_enable && is_slave;

  telegram_checker u_bus_rx (
    .clk(clk),
    .reset(reset),
    .line_raw(bus_rx_line),
    .enable(rx_enable),
    .master_call_ok(bus_mc),
    .slave_resp_ok(bus_sr),
    .word(bus_word)
  );

  telegram_checker u_aux_rx (
    .clk(clk),
    .reset(reset),
    .line_raw(aux_channel_pin),
    .enable(aux_rx_enable),
    .master_call_ok(aux_mc),
    .slave_resp_ok(),
    .word(aux_word)
  );

  // ---------------------------------------------------------------
  // clock watchdog
  // ---------------------------------------------------------------
  // counts cycles since the last oscillator edge; held while it stays quiet
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      osc_prev <= 1'b0;
      wd_cnt <= '0;
      wd_active <= 1'b0;
    end else begin
      osc_prev <= osc_s;
      if (osc_s != osc_prev) begin
        wd_cnt <= '0;
        wd_active <= 1'b0;
      end else if (wd_cnt == 10'(supervisor_pkg::WATCHDOG_CYCLES)) begin
        wd_active <= 1'b1;
      end else begin
        wd_cnt <= wd_cnt + 10'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // thermal and short-circuit shutdown
  // ---------------------------------------------------------------
  assign trip = temp_s && temp_cnt == 27'(OVERTEMP_CYCLES);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      temp_cnt <= '0;
    end else if (!temp_s) begin
      temp_cnt <= '0;
    end else if (temp_cnt != 27'(OVERTEMP_CYCLES)) begin
      temp_cnt <= temp_cnt + 27'd1;
    end
  end

  // only the power-on reset clears the latch, nothing internal does
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shutdown <= 1'b0;
      inductor_enable <= 1'b1;
      analog_power_down <= 1'b0;
    end else begin
      if (trip || short_s) begin
        shutdown <= 1'b1;
        inductor_enable <= 1'b0;
        analog_power_down <= 1'b1;
      end
    end
  end

  // device reset: watchdog level plus one pulse on shutdown entry
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dev_rst <= 1'b0;
    end else begin
      dev_rst <= wd_active || ((trip || short_s) && !shutdown);
    end
  end
  assign device_reset = dev_rst;

  // ---------------------------------------------------------------
  // operating mode
  // ---------------------------------------------------------------
  assign is_slave = mode_valid && mode == supervisor_pkg::MODE_SLAVE;
  assign is_master_family = mode_valid && mode != supervisor_pkg::MODE_SLAVE;

  // loaded once per initialization, so the mode cannot move while running
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode <= supervisor_pkg::MODE_SLAVE;
      mode_valid <= 1'b0;
    end else if (dev_rst) begin
      mode_valid <= 1'b0;
    end else if (!mode_valid && nvm_ready && !shutdown) begin
      mode_valid <= 1'b1;
      unique case ({nvm_master_flag, nvm_repeater_flag})
        2'b00: mode <= supervisor_pkg::MODE_SLAVE;
        2'b10: mode <= supervisor_pkg::MODE_MASTER;
        2'b11: mode <= supervisor_pkg::MODE_REPEATER;
        2'b01: mode <= supervisor_pkg::MODE_MONITOR;
      endcase
    end
  end

  // decoded mode flags and slave-only permissions
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_slave <= 1'b0;
      mode_master <= 1'b0;
      mode_repeater <= 1'b0;
      mode_monitor <= 1'b0;
      nvm_write_enable <= 1'b0;
      io_enable <= 1'b0;
    end else begin
      mode_slave <= is_slave;
      mode_master <= mode_valid && mode == supervisor_pkg::MODE_MASTER;
      mode_repeater <= mode_valid && mode == supervisor_pkg::MODE_REPEATER;
      mode_monitor <= mode_valid && mode == supervisor_pkg::MODE_MONITOR;
      nvm_write_enable <= is_slave && !shutdown;
      io_enable <= is_slave && !shutdown;
    end
  end

  // ---------------------------------------------------------------
  // crystal frequency detection and lock
  // ---------------------------------------------------------------
  assign lock_event = is_slave ? (bus_mc || (aux_enabled && aux_mc))
                               : (is_master_family && (bus_mc || bus_sr));

  // the lock survives device resets; only power-on reopens detection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      det_cnt <= '0;
      det_done <= 1'b0;
      freq_16mhz <= supervisor_pkg::FREQ_16_RESET;
      freq_locked <= 1'b0;
    end else begin
      if (!det_done) begin
        if (det_cnt == 14'(DETECT_CYCLES - 1)) begin
          det_done <= 1'b1;
        end else begin
          det_cnt <= det_cnt + 14'd1;
        end
      end
      if (det_done && !freq_locked) begin
        freq_16mhz <= !xtal8_s;
      end
      if (lock_event) begin
        freq_locked <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // receive thresholds
  // ---------------------------------------------------------------
  // half of the first pulse level, rounded up
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pos_threshold <= '0;
      neg_threshold <= '0;
    end else if (amp_valid) begin
      pos_threshold <= 3'(({1'b0, amp_code} + 4'd1) >> 1);
      neg_threshold <= 3'(({1'b0, amp_code} + 4'd1) >> 1);
    end
  end

  // ---------------------------------------------------------------
  // aux channel enable and strobes
  // ---------------------------------------------------------------
  assign aux_magic = aux_mc && aux_word == ACTIVATION_CALL;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aux_enabled <= 1'b0;
    end else if (dev_rst) begin
      aux_enabled <= 1'b0;
    end else if (is_slave && aux_magic) begin
      aux_enabled <= 1'b1;
    end
  end

  // strobes are one cycle, one per checked telegram
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strobe_master_call <= 1'b0;
      strobe_slave_resp <= 1'b0;
      rx_word <= '0;
    end else begin
      strobe_master_call <= (is_slave && (bus_mc || (aux_enabled && aux_mc && !aux_magic)))
        || (mode_valid && mode == supervisor_pkg::MODE_MONITOR && bus_mc);
      strobe_slave_resp <= is_master_family && bus_sr;
      if (is_slave && aux_enabled && aux_mc && !bus_mc) begin
        rx_word <= aux_word;
      end else if (bus_mc || bus_sr) begin
        rx_word <= bus_word;
      end
    end
  end

  // ---------------------------------------------------------------
  // response encoder
  // ---------------------------------------------------------------
  // first half carries the bit, second half its inverse
  assign tx_level = tx_half[0] ? !tx_shift[6] : tx_shift[6];

  // a load while busy is ignored; the state machine waits for tx_enable low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_busy <= 1'b0;
      tx_shift <= '0;
      tx_half <= '0;
      tx_cnt <= '0;
    end else if (!tx_busy) begin
      if (resp_load && is_slave && !shutdown) begin
        tx_busy <= 1'b1;
        tx_shift <= {1'b0, resp_data, ^resp_data, 1'b1};
        tx_half <= '0;
        tx_cnt <= '0;
      end
    end else if (tx_cnt == 8'(supervisor_pkg::HALF_BIT_CYCLES - 1)) begin
      tx_cnt <= '0;
      if (tx_half == 4'(supervisor_pkg::TX_HALVES - 1)) begin
        tx_busy <= 1'b0;
      end else begin
        tx_half <= tx_half + 4'd1;
      end
      if (tx_half[0]) begin
        tx_shift <= {tx_shift[5:0], 1'b0};
      end
    end else begin
      tx_cnt <= tx_cnt + 8'd1;
    end
  end

  // bus driver: encoder in slave mode, aux pin passthrough otherwise
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_enable <= 1'b0;
      tx_manchester <= 1'b1;
      first_indicator_pin <= 1'b0;
    end else begin
      if (is_master_family) begin
        tx_enable <= 1'b1;
        tx_manchester <= pin[7];
      end else begin
        tx_enable <= tx_busy && !aux_enabled;
        tx_manchester <= tx_busy ? tx_level : 1'b1;
      end
      first_indicator_pin <= aux_enabled && tx_busy && !tx_level;
    end
  end

  // ---------------------------------------------------------------
  // fail pin and aux path selection
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fail_digital_level <= 1'b0;
      fail_comparator_enable <= 1'b0;
      power_fail <= 1'b0;
      aux_current_path <= 1'b0;
    end else begin
      fail_digital_level <= is_slave && fail_s;
      fail_comparator_enable <= is_master_family;
      power_fail <= is_master_family && fcmp_s;
      aux_current_path <= is_slave && auxc_s;
    end
  end

endmodule

/* File: sim/supervisor_checker.sv */
`timescale 1ns/100ps
module supervisor_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic amp_valid,
  input wire logic [2:0] amp_code,
  input wire logic osc_activity,
  input wire logic inductor_short,
  input wire logic mode_slave,
  input wire logic mode_master,
  input wire logic mode_repeater,
  input wire logic mode_monitor,
  input wire logic mode_valid,
  input wire logic nvm_write_enable,
  input wire logic io_enable,
  input wire logic freq_16mhz,
  input wire logic freq_locked,
  input wire logic device_reset,
  input wire logic inductor_enable,
  input wire logic analog_power_down,
  input wire logic [2:0] pos_threshold,
  input wire logic strobe_master_call,
  input wire logic strobe_slave_resp
);
  logic [9:0] quiet;
  logic osc_q;
  // quiet-clock count, saturating so a long stall never wraps to zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      quiet <= 10'h0;
      osc_q <= 1'b0;
    end else begin
      osc_q <= osc_activity;
      if (osc_activity != osc_q) quiet <= 10'h0;
      else if (quiet != 10'h3ff) quiet <= quiet + 10'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_mode_onehot: assert property ($onehot0({mode_slave, mode_master, mode_repeater, mode_monitor}))
    else $error("several modes active");
  chk_mode_frozen: assert property (mode_valid && $past(mode_valid, 2) |-> $stable({mode_slave, mode_master, mode_monitor}))
    else $error("mode changed while running");
  chk_slave_access: assert property (io_enable || nvm_write_enable |-> mode_slave)
    else $error("access outside slave mode");
  chk_lock_freeze: assert property (freq_locked |=> freq_locked && $stable(freq_16mhz))
    else $error("frequency moved after lock");
  chk_clock_dog: assert property (quiet >= 10'h32a |-> device_reset)
    else $error("no reset on stalled clock");
  chk_shut_latched: assert property (analog_power_down |=> analog_power_down && !inductor_enable)
    else $error("shutdown left early");
  chk_short_trip: assert property (inductor_short [*6] |-> !inductor_enable && analog_power_down)
    else $error("short did not shut down");
  chk_amp_half: assert property (amp_valid |=> pos_threshold == 3'((4'($past(amp_code)) + 4'h1) >> 1))
    else $error("threshold not half of amplitude");
  chk_slave_quiet: assert property (strobe_slave_resp |-> !mode_slave)
    else $error("response strobe in slave mode");
  chk_call_pulse: assert property (strobe_master_call |=> !strobe_master_call)
    else $error("call strobe too long");
  chk_resp_pulse: assert property (strobe_slave_resp |=> !strobe_slave_resp)
    else $error("response strobe too long");
  cov_call: cover property (strobe_master_call);
  cov_resp: cover property (strobe_slave_resp);
  cov_down: cover property ($rose(analog_power_down));
endmodule
bind node_mode_supervisor supervisor_checker u_chk (.*);

/* File: sim/bus_node_model.sv */
`timescale 1ns/100ps
module bus_node_model (
  input wire logic clk,
  output logic line
);
  initial line = 1'b1;
  // one telegram msb first, level then inverse; a long idle tail keeps frames apart
  task automatic send(input logic [13:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      line = w[i];
      repeat (120) @(negedge clk);
      line = ~w[i];
      repeat (120) @(negedge clk);
    end
    line = 1'b1;
    repeat (600) @(negedge clk);
  endtask
endmodule

/* File: sim/tb.sv */
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0, reset = 1'b1, nvm_ready = 1'b0, nvm_master_flag = 1'b0;
  logic nvm_repeater_flag = 1'b0, amp_valid = 1'b0, osc_activity = 1'b0, osc_run = 1'b1;
  logic crystal_is_8mhz = 1'b0, temp_high = 1'b0, inductor_short = 1'b0, resp_load = 1'b0;
  logic fail_input_pin = 1'b1, fail_comparator = 1'b1, aux_current_detect = 1'b0;
  logic [2:0] amp_code = 3'h0;
  logic [3:0] resp_data = 4'hb;
  logic bus_rx_line, aux_channel_pin, mode_slave, mode_master, mode_repeater, mode_monitor;
  logic mode_valid, nvm_write_enable, io_enable, freq_16mhz, freq_locked, device_reset;
  logic inductor_enable, analog_power_down, tx_enable, tx_manchester, strobe_master_call;
  logic strobe_slave_resp, first_indicator_pin, aux_enabled, aux_current_path;
  logic fail_digital_level, fail_comparator_enable, power_fail;
  logic [2:0] pos_threshold, neg_threshold;
  logic [13:0] rx_word, txw;
  logic [3:0] exp_m [4] = '{4'h8, 4'h1, 4'h4, 4'h2};
  int mismatches = 0, n_compared = 0, n_mc = 0, n_sr = 0, cycles = 0;
  node_mode_supervisor #(.DETECT_CYCLES(50), .OVERTEMP_CYCLES(20)) DUT (.*);
  bus_node_model bus (.clk(clk), .line(bus_rx_line));
  bus_node_model aux (.clk(clk), .line(aux_channel_pin));
  always #12.5 clk = ~clk;
  // crystal activity, stopped only for the watchdog test
  always @(negedge clk) if (osc_run && cycles % 4 == 0) osc_activity <= ~osc_activity;
  // strobe tallies; the cycle ceiling cuts a hang short
  always @(posedge clk) begin
    n_mc <= n_mc + int'(strobe_master_call);
    n_sr <= n_sr + int'(strobe_slave_resp);
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // reset for 5 cycles, then present the stored flags
  task automatic boot(input logic m, input logic r);
    reset = 1'b1;
    nvm_ready = 1'b0;
    nvm_master_flag = m;
    nvm_repeater_flag = r;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    nvm_ready = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  function automatic logic [13:0] call(input logic [10:0] p);
    return {1'b0, p, ^p, 1'b1};
  endfunction
  function automatic logic [13:0] resp(input logic [3:0] d);
    return {7'h0, 1'b0, d, ^d, 1'b1};
  endfunction
  task automatic tel(input logic [13:0] w, input int n, input int emc, input int esr);
    int a;
    int b;
    a = n_mc;
    b = n_sr;
    bus.send(w, n);
    check(14'(n_mc - a), 14'(emc));
    check(14'(n_sr - b), 14'(esr));
  endtask
  task automatic load_resp();
    resp_load = 1'b1;
    @(negedge clk);
    resp_load = 1'b0;
    repeat (61) @(negedge clk);
  endtask
  initial begin
    @(negedge clk);
    // every mode: selection, access, strobes
    for (int k = 0; k < 4; k++) begin
      boot(k[1], k[0]);
      check(14'({mode_slave, mode_master, mode_repeater, mode_monitor}), 14'(exp_m[k]));
      check(14'({mode_valid, io_enable, nvm_write_enable}), (k == 0) ? 14'h7 : 14'h4);
      if (!k[0]) check(14'({fail_comparator_enable, tx_enable}), k[1] ? 14'h3 : 14'h0);
      check(14'({tx_manchester, fail_digital_level, power_fail}), k ? 14'h5 : 14'h6);
      tel(call(11'h2a5), 14, k < 2, 0);
      if (k == 0) check(rx_word, call(11'h2a5));
      tel(resp(4'h9), 7, 0, k != 0);
      nvm_master_flag = ~nvm_master_flag;
      repeat (3) @(negedge clk);
      check(14'({mode_slave, mode_master, mode_repeater, mode_monitor}), 14'(exp_m[k]));
    end
    $display("test modes done");
    crystal_is_8mhz = 1'b1;
    boot(0, 0);
    check(14'(freq_16mhz), 14'h1);
    repeat (60) @(negedge clk);
    check(14'(freq_16mhz), 14'h0);
    tel(call(11'h155) ^ 14'h4, 14, 0, 0);
    tel(resp(4'h3), 7, 0, 0);
    check(14'(freq_locked), 14'h0);
    tel(call(11'h155), 14, 1, 0);
    crystal_is_8mhz = 1'b0;
    repeat (10) @(negedge clk);
    check(14'({freq_locked, freq_16mhz}), 14'h2);
    $display("test frequency done");
    for (int c = 0; c < 8; c++) begin
      amp_code = 3'(c);
      amp_valid = 1'b1;
      @(negedge clk);
      amp_valid = 1'b0;
      repeat (2) @(negedge clk);
      check(14'({pos_threshold, neg_threshold}), 14'({2{3'((c + 1) / 2)}}));
    end
    // response frame sampled mid-half; start bit first
    txw = resp(resp_data);
    load_resp();
    for (int h = 0; h < 14; h++) begin
      check(14'({tx_enable, tx_manchester}), 14'({1'b1, txw[6 - h / 2] ^ h[0]}));
      repeat (120) @(negedge clk);
    end
    aux.send(supervisor_pkg::ACTIVATION_CALL_DEFAULT, 14);
    check(14'(aux_enabled), 14'h1);
    aux_current_detect = 1'b1;
    load_resp();
    check(14'({tx_enable, first_indicator_pin, aux_current_path}), 14'h3);
    repeat (120) @(negedge clk);
    check(14'({tx_enable, first_indicator_pin}), 14'h0);
    $display("test transmit done");
    osc_run = 1'b0;
    repeat (820) @(negedge clk);
    check(14'({device_reset, aux_enabled}), 14'h2);
    osc_run = 1'b1;
    repeat (20) @(negedge clk);
    check(14'(device_reset), 14'h0);
    temp_high = 1'b1;
    repeat (15) @(negedge clk);
    check(14'(inductor_enable), 14'h1);
    repeat (15) @(negedge clk);
    temp_high = 1'b0;
    repeat (20) @(negedge clk);
    check(14'({inductor_enable, analog_power_down, io_enable}), 14'h2);
    boot(0, 0);
    inductor_short = 1'b1;
    repeat (8) @(negedge clk);
    inductor_short = 1'b0;
    repeat (5) @(negedge clk);
    check(14'({inductor_enable, analog_power_down}), 14'h1);
    $display("test protection done");
    complete_run();
  end
endmodule
